// >>> design/sleep_sub_cfg.svh
// Constants for the power-down and subtract-from-literal execution logic
`ifndef SLEEP_SUB_CFG_SVH
`define SLEEP_SUB_CFG_SVH

// ---------------------------------------------------------------
// Instruction encodings
// ---------------------------------------------------------------
`define POWER_DOWN_WORD 16'h0003
`define SUBTRACT_FROM_LITERAL_HI 8'hb2
`define OPCODE_HI_MSB 15
`define OPCODE_HI_LSB 8
`define LITERAL_MSB 7
`define LITERAL_LSB 0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define WORKING_REGISTER_RESET 8'h00
`define POWER_DOWN_FLAG_N_RESET 1'b1
`define TIMEOUT_FLAG_N_RESET 1'b1
`define ARITH_FLAGS_RESET 4'h0

`endif

// >>> design/sleep_sub_pkg.sv
// Types shared by the power-down and subtract-from-literal execution logic
package sleep_sub_pkg;

    // ---------------------------------------------------------------
    // Arithmetic status flags
    // ---------------------------------------------------------------
    typedef struct packed {
        logic overflow_flag;
        logic carry_flag;
        logic digit_carry_flag;
        logic zero_flag;
    } arith_flags_type;

    // ---------------------------------------------------------------
    // Core run state
    // ---------------------------------------------------------------
    typedef enum logic [0:0] {
        CORE_RUN,
        CORE_HALTED
    } core_state_type;

endpackage

// >>> design/literal_subtract_alu.sv
// Combinational literal-minus-working-register subtractor with flags
`timescale 1ns/100ps
`include "sleep_sub_cfg.svh"

module literal_subtract_alu
    import sleep_sub_pkg::*;
(
    input wire logic [7:0] literal_value, // Literal operand k
    input wire logic [7:0] subtrahend, // Current working register
    output logic [7:0] difference, // k minus working register
    output arith_flags_type flags // Resulting arithmetic flags
);

    // ---------------------------------------------------------------
    // Two's complement subtract
    // ---------------------------------------------------------------
    logic [8:0] full_sum;
    logic [4:0] nibble_sum;

    // Add the inverted operand plus one, so carry out means no borrow
    always_comb begin
        full_sum = {1'b0, literal_value} + {1'b0, ~subtrahend} + 9'h001;
        nibble_sum = {1'b0, literal_value[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
        difference = full_sum[7:0];
        flags.carry_flag = full_sum[8];
        flags.digit_carry_flag = nibble_sum[4];
        // Signed overflow: operand signs differ and result sign leaves the literal's
        flags.overflow_flag = (literal_value[7] != subtrahend[7]) &&
                              (full_sum[7] != literal_value[7]);
        flags.zero_flag = (full_sum[7:0] == 8'h00);
    end

endmodule

// >>> design/sleep_and_literal_subtract_exec.sv
// Execution logic for the power-down and subtract-from-literal instructions
//
// Function
// - Executing power-down clears the active-low power-down flag to zero.
// - Executing power-down sets the active-low time-out flag to one.
// - Executing power-down resets the watchdog counter and its prescaler.
// - After power-down the core halts with its oscillator stopped until a wake-up event.
// - A wake-up caused by watchdog time-out clears the time-out flag.
// - Subtract-from-literal stores the literal minus the working register into the working register.
`timescale 1ns/100ps
`include "sleep_sub_cfg.svh"

module sleep_and_literal_subtract_exec
    import sleep_sub_pkg::*;
(
    input wire logic clk_sys, // Core clock, 10 MHz
    input wire logic reset, // Synchronous reset, active high
    input wire logic [15:0] instr_word, // Decoded instruction word
    input wire logic instr_valid, // Instruction word executes this cycle
    output logic instr_ready, // Core accepts instructions (not halted)
    input wire logic working_load, // Other instruction writes working register
    input wire logic [7:0] working_load_data, // Data for that write
    input wire logic watchdog_timeout, // Watchdog time-out pulse, same clock
    input wire logic wake_event, // Internal wake-up source, same clock
    input wire logic wake_pin_async, // External wake-up pin, asynchronous
    output logic [7:0] working_register, // Working register contents
    output arith_flags_type arith_flags, // Overflow, carry, digit-carry, zero
    output logic power_down_flag_n, // Power-down status, active low
    output logic timeout_flag_n, // Time-out status, active low
    output logic watchdog_clear, // One-cycle clear of watchdog and prescaler
    output logic core_halted, // Core is in the low-power halted state
    output logic oscillator_enable, // Oscillator runs when high
    output logic woke_by_watchdog // Last wake-up came from the watchdog
);

    // ---------------------------------------------------------------
    // Instruction decode
    // ---------------------------------------------------------------
    // Execute strobes, already qualified by ready
    logic exec_power_down;
    logic exec_subtract;
    logic [7:0] literal_value;

    // Only decode while running; a halted core sees no instructions
    always_comb begin
        exec_power_down = instr_valid && instr_ready && (instr_word == `POWER_DOWN_WORD);
        exec_subtract = instr_valid && instr_ready &&
                        (instr_word[`OPCODE_HI_MSB:`OPCODE_HI_LSB] == `SUBTRACT_FROM_LITERAL_HI);
        literal_value = instr_word[`LITERAL_MSB:`LITERAL_LSB];
    end

    // ---------------------------------------------------------------
    // Wake pin synchroniser
    // ---------------------------------------------------------------
    // Pin stages; only the second one is read by logic
    logic wake_meta_reg;
    logic wake_meta_next;
    logic wake_sync_reg;
    logic wake_sync_next;

    // First stage feeds only the second stage
    always_comb begin
        wake_meta_next = wake_pin_async;
        wake_sync_next = wake_meta_reg;
    end

    // Two flops against metastability on the pin
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wake_meta_reg <= 1'b0;
            wake_sync_reg <= 1'b0;
        end else begin
            wake_meta_reg <= wake_meta_next;
            wake_sync_reg <= wake_sync_next;
        end
    end

    // ---------------------------------------------------------------
    // Run/halt state and power status flags
    // ---------------------------------------------------------------
    core_state_type state_reg;
    core_state_type state_next;
    logic power_down_n_reg;
    logic power_down_n_next;
    logic timeout_n_reg;
    logic timeout_n_next;
    logic watchdog_clear_reg;
    logic watchdog_clear_next;
    logic woke_watchdog_reg;
    logic woke_watchdog_next;
    logic any_wake;

    // Any source ends the halt; the pin arrives two cycles late through the synchroniser
    always_comb begin
        any_wake = watchdog_timeout || wake_event || wake_sync_reg;
    end

    // Watchdog wake takes priority so its flag update is never missed
    always_comb begin
        state_next = state_reg;
        power_down_n_next = power_down_n_reg;
        timeout_n_next = timeout_n_reg;
        watchdog_clear_next = 1'b0;
        woke_watchdog_next = woke_watchdog_reg;
        case (state_reg)
            CORE_RUN: begin
                if (exec_power_down) begin
                    power_down_n_next = 1'b0;
                    timeout_n_next = 1'b1;
                    watchdog_clear_next = 1'b1;
                    woke_watchdog_next = 1'b0;
                    state_next = CORE_HALTED;
                end
            end
            CORE_HALTED: begin
                // Wake leaves the power-down flag low; only reset raises it
                if (any_wake) begin
                    state_next = CORE_RUN;
                    if (watchdog_timeout) begin
                        timeout_n_next = 1'b0;
                        woke_watchdog_next = 1'b1;
                    end
                end
            end
            default: begin
                state_next = CORE_RUN;
            end
        endcase
    end

    // Power-on values: both active-low status flags read one
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= CORE_RUN;
            power_down_n_reg <= `POWER_DOWN_FLAG_N_RESET;
            timeout_n_reg <= `TIMEOUT_FLAG_N_RESET;
            watchdog_clear_reg <= 1'b0;
            woke_watchdog_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            power_down_n_reg <= power_down_n_next;
            timeout_n_reg <= timeout_n_next;
            watchdog_clear_reg <= watchdog_clear_next;
            woke_watchdog_reg <= woke_watchdog_next;
        end
    end

    // ---------------------------------------------------------------
    // Subtract datapath
    // ---------------------------------------------------------------
    // Working register state, declared ahead of the subtractor that reads it
    logic [7:0] working_value_reg;
    logic [7:0] working_value_next;
    arith_flags_type flags_reg;
    arith_flags_type flags_next;
    logic [7:0] difference;
    arith_flags_type alu_flags;

    // Subtractor is purely combinational; the result lands at the next edge
    literal_subtract_alu alu (
        .literal_value(literal_value),
        .subtrahend(working_value_reg),
        .difference(difference),
        .flags(alu_flags)
    );

    // ---------------------------------------------------------------
    // Working register load qualification
    // ---------------------------------------------------------------
    logic load_accept;

    // A halted core refuses loads, and a subtract in the same cycle wins
    always_comb begin
        load_accept = working_load && instr_ready && !exec_subtract;
    end

    // ---------------------------------------------------------------
    // Working register and arithmetic flags
    // ---------------------------------------------------------------
    // Plain loads leave the arithmetic flags alone
    always_comb begin
        working_value_next = working_value_reg;
        flags_next = flags_reg;
        if (exec_subtract) begin
            working_value_next = difference;
            flags_next = alu_flags;
        end else if (load_accept) begin
            working_value_next = working_load_data;
        end
    end

    // Halted core keeps its state because nothing executes
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            working_value_reg <= `WORKING_REGISTER_RESET;
            flags_reg <= `ARITH_FLAGS_RESET;
        end else begin
            working_value_reg <= working_value_next;
            flags_reg <= flags_next;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    // Oscillator gating follows the halt state directly, so it stops at the next edge
    always_comb begin
        instr_ready = (state_reg == CORE_RUN);
        core_halted = (state_reg == CORE_HALTED);
        oscillator_enable = (state_reg == CORE_RUN);
    end

    // Status and data outputs are straight flop copies, free of decode glitches
    always_comb begin
        working_register = working_value_reg;
        arith_flags = flags_reg;
        power_down_flag_n = power_down_n_reg;
        timeout_flag_n = timeout_n_reg;
        watchdog_clear = watchdog_clear_reg;
        woke_by_watchdog = woke_watchdog_reg;
    end

endmodule

// >>> bench/sleep_sub_exec_props.sv
// Port checks for the power-down and subtract execution logic
`timescale 1ns/100ps
`include "sleep_sub_cfg.svh"
module sleep_sub_exec_props
    import sleep_sub_pkg::*;
(
    input wire logic clk_sys, // Clock
    input wire logic reset, // Reset
    input wire logic [15:0] instr_word, // Word
    input wire logic instr_valid, // Valid
    input wire logic instr_ready, // Ready
    input wire logic watchdog_timeout, // Time-out
    input wire logic [7:0] working_register, // W
    input wire arith_flags_type arith_flags, // Flags
    input wire logic power_down_flag_n, // Power-down status
    input wire logic timeout_flag_n, // Time-out status
    input wire logic watchdog_clear, // Clear pulse
    input wire logic core_halted, // Halted
    input wire logic oscillator_enable, // Osc on
    input wire logic woke_by_watchdog // Wake cause
);
    // ----------------------------------------
    // Accepted instructions and watchdog wake
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    wire sleep_go = instr_valid && instr_ready && (instr_word == `POWER_DOWN_WORD);
    wire sub_go = instr_valid && instr_ready && (instr_word[15:8] == `SUBTRACT_FROM_LITERAL_HI);
    property p_pwrdn_flag; sleep_go |=> !power_down_flag_n; endproperty
    a_pwrdn_flag: assert property (p_pwrdn_flag) else $error("power-down flag not cleared");
    property p_tmo_set; sleep_go |=> timeout_flag_n; endproperty
    a_tmo_set: assert property (p_tmo_set) else $error("time-out flag not set");
    property p_wdc; sleep_go |=> watchdog_clear ##1 !watchdog_clear; endproperty
    a_wdc: assert property (p_wdc) else $error("bad clear pulse");
    property p_halt; sleep_go |=> core_halted && !oscillator_enable && !instr_ready; endproperty
    a_halt: assert property (p_halt) else $error("no halt");
    property p_wake;
        core_halted && watchdog_timeout |=> !core_halted && !timeout_flag_n && woke_by_watchdog;
    endproperty
    a_wake: assert property (p_wake) else $error("bad watchdog wake");
    property p_sub;
        sub_go |=> working_register == $past(instr_word[7:0]) - $past(working_register);
    endproperty
    a_sub: assert property (p_sub) else $error("bad difference");
    property p_c;
        sub_go |=> arith_flags.carry_flag == ($past(instr_word[7:0]) >= $past(working_register));
    endproperty
    a_c: assert property (p_c) else $error("bad carry");
    property p_z;
        sub_go |=> arith_flags.zero_flag == ($past(instr_word[7:0]) == $past(working_register));
    endproperty
    a_z: assert property (p_z) else $error("bad zero");
    property p_dc;
        sub_go |=> arith_flags.digit_carry_flag == ($past(instr_word[3:0]) >= $past(working_register[3:0]));
    endproperty
    a_dc: assert property (p_dc) else $error("bad digit carry");
    property p_ov;
        sub_go |=> arith_flags.overflow_flag == (($past(instr_word[7]) != $past(working_register[7])) &&
            (working_register[7] != $past(instr_word[7])));
    endproperty
    a_ov: assert property (p_ov) else $error("bad overflow");
endmodule
bind sleep_and_literal_subtract_exec sleep_sub_exec_props u_props (
    .clk_sys(clk_sys),
    .reset(reset),
    .instr_word(instr_word),
    .instr_valid(instr_valid),
    .instr_ready(instr_ready),
    .watchdog_timeout(watchdog_timeout),
    .working_register(working_register),
    .arith_flags(arith_flags),
    .power_down_flag_n(power_down_flag_n),
    .timeout_flag_n(timeout_flag_n),
    .watchdog_clear(watchdog_clear),
    .core_halted(core_halted),
    .oscillator_enable(oscillator_enable),
    .woke_by_watchdog(woke_by_watchdog)
);

// >>> bench/tb.sv
// Self-checking bench for the power-down and subtract execution logic
`timescale 1ns/100ps
`include "sleep_sub_cfg.svh"
module tb;
    import sleep_sub_pkg::*;
    logic clk_sys = 1'h0, reset = 1'h1, instr_valid = 1'h0, working_load = 1'h0;
    logic watchdog_timeout = 1'h0, wake_event = 1'h0, wake_pin_async = 1'h0;
    logic [15:0] instr_word = 16'h0;
    logic [7:0] working_load_data = 8'h0, working_register;
    logic instr_ready, power_down_flag_n, timeout_flag_n, watchdog_clear;
    logic core_halted, oscillator_enable, woke_by_watchdog;
    arith_flags_type arith_flags;
    int err_count = 0, cmp_count = 0;
    sleep_and_literal_subtract_exec DUT (
        .clk_sys(clk_sys),
        .reset(reset),
        .instr_word(instr_word),
        .instr_valid(instr_valid),
        .instr_ready(instr_ready),
        .working_load(working_load),
        .working_load_data(working_load_data),
        .watchdog_timeout(watchdog_timeout),
        .wake_event(wake_event),
        .wake_pin_async(wake_pin_async),
        .working_register(working_register),
        .arith_flags(arith_flags),
        .power_down_flag_n(power_down_flag_n),
        .timeout_flag_n(timeout_flag_n),
        .watchdog_clear(watchdog_clear),
        .core_halted(core_halted),
        .oscillator_enable(oscillator_enable),
        .woke_by_watchdog(woke_by_watchdog)
    );
    // ----------------------------------------
    // Clock, compare and close
    // ----------------------------------------
    always #50 clk_sys = ~clk_sys;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Load W, then subtract at the very next edge
    task automatic t_sub(input logic [7:0] w, input logic [7:0] k);
        logic [7:0] r;
        arith_flags_type f;
        r = k - w;
        f = {(k[7] != w[7]) && (r[7] != k[7]), k >= w, k[3:0] >= w[3:0], r == 8'h00};
        @(posedge clk_sys);
        working_load <= 1'h1;
        working_load_data <= w;
        @(posedge clk_sys);
        working_load <= 1'h0;
        instr_valid <= 1'h1;
        instr_word <= {`SUBTRACT_FROM_LITERAL_HI, k};
        @(posedge clk_sys);
        instr_valid <= 1'h0;
        #1;
        chk(16'(working_register), 16'(r));
        chk(16'(arith_flags), 16'(f));
    endtask
    // Power-down, refused traffic, then wake from source src
    task automatic t_wake(input int src);
        logic [7:0] w0;
        arith_flags_type f0;
        int n;
        @(posedge clk_sys);
        instr_valid <= 1'h1;
        instr_word <= `POWER_DOWN_WORD;
        @(posedge clk_sys);
        instr_valid <= 1'h0;
        #1;
        w0 = working_register;
        f0 = arith_flags;
        chk(16'(power_down_flag_n), 16'h0);
        chk(16'(timeout_flag_n), 16'h1);
        chk(16'(watchdog_clear), 16'h1);
        chk(16'({core_halted, oscillator_enable, instr_ready}), 16'h4);
        @(posedge clk_sys);
        instr_valid <= 1'h1;
        instr_word <= {`SUBTRACT_FROM_LITERAL_HI, 8'h55};
        working_load <= 1'h1;
        working_load_data <= 8'ha5;
        #1;
        chk(16'(watchdog_clear), 16'h0);
        @(posedge clk_sys);
        instr_valid <= 1'h0;
        working_load <= 1'h0;
        watchdog_timeout <= (src == 0);
        wake_event <= (src == 1);
        wake_pin_async <= (src == 2);
        #1;
        chk(16'({core_halted, working_register}), {8'h1, w0});
        chk(16'(arith_flags), 16'(f0));
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (core_halted !== 1'h0 && n < 8);
        chk(16'(n), (src == 2) ? 16'h3 : 16'h1);
        chk(16'({oscillator_enable, instr_ready, power_down_flag_n}), 16'h6);
        chk(16'({timeout_flag_n, woke_by_watchdog}), (src == 0) ? 16'h1 : 16'h2);
        @(posedge clk_sys);
        watchdog_timeout <= 1'h0;
        wake_event <= 1'h0;
        wake_pin_async <= 1'h0;
        #1;
        chk(16'(core_halted), 16'h0);
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'h0;
        t_sub(8'h01, 8'h02);
        t_sub(8'h02, 8'h02);
        t_sub(8'h03, 8'h02);
        t_sub(8'h01, 8'h80);
        t_sub(8'h80, 8'h7f);
        t_sub(8'h01, 8'h10);
        t_wake(0);
        t_wake(1);
        t_wake(2);
        complete_run();
    end
    initial begin
        #500000;
        err_count++;
        complete_run();
    end
endmodule
